/* hw/rmv_top.sv */
// Operation
// - On reset release, copy the four mode pins into the mode register.
// - Low mode bits 001 select byte-wide memory boot; top bit ignored.
// - Low mode bits 100 to 111 select host-port boot, four bus styles.
// - 24-bit vector base, read/write; low eight bits read zero always.
// - Vector base gives each source a two-word slot: vector and next.
// - Interrupt logic uses base implicitly; control moves read/write it.
// - Offsets 00,02,04,06,08 for reset,stack,illegal,debug,trap; level 3.
module rmv_top (
  input wire logic mclk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic [rmv_pkg::MODE_W-1:0] boot_select_pins, // Mode pins d..a
  input wire logic ctl_wr, // Control move write to vector base
  input wire logic [rmv_pkg::ADDR_W-1:0] ctl_wdata, // Control move data
  output logic [rmv_pkg::ADDR_W-1:0] ctl_rdata, // Vector base readback
  input wire logic exc_req, // Sequencer asks for a vector fetch
  input wire logic [rmv_pkg::SRC_W-1:0] exc_src, // Source of the request
  input wire logic exc_second, // Fetch the word after the vector
  output logic [rmv_pkg::ADDR_W-1:0] vec_addr, // Registered fetch address
  output logic [rmv_pkg::PRI_W-1:0] vec_level, // Registered priority
  output logic vec_valid, // One-cycle pulse with address
  output logic [rmv_pkg::MODE_W-1:0] operating_mode_reg, // Captured mode
  output logic mode_bit_d, // Mode bit d
  output logic mode_bit_c, // Mode bit c
  output logic mode_bit_b, // Mode bit b
  output logic mode_bit_a, // Mode bit a
  output rmv_pkg::rmv_boot_t boot_kind, // Decoded boot source
  output logic [1:0] host_bus_style // Host bus style, modes 4..7 and 12..15
);
  // ****************************************
  // Mode capture
  // ****************************************
  logic [rmv_pkg::MODE_W-1:0] mode_r;
  logic rst_seen_r;

  // Async reset cannot load a pin value, so the pins are taken on the
  // first clock after release; later pin changes never reach the mode.
  wire capture = !rst_seen_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rst_seen_r <= 1'b0;
    end else begin
      rst_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_r <= rmv_pkg::MODE_RESET;
    end else if (capture) begin
      mode_r <= boot_select_pins;
    end
  end

  // ****************************************
  // Mode outputs
  // ****************************************
  // Mode bits are plain taps of the register, with no extra delay.
  assign operating_mode_reg = mode_r;
  assign mode_bit_d = mode_r[rmv_pkg::BIT_D];
  assign mode_bit_c = mode_r[rmv_pkg::BIT_C];
  assign mode_bit_b = mode_r[rmv_pkg::BIT_B];
  assign mode_bit_a = mode_r[rmv_pkg::BIT_A];

  // ****************************************
  // Boot decode
  // ****************************************
  // The pins are decoded, not the mode register, so the boot source and
  // bus style load on the capture edge and come straight from flops.
  // The top mode bit takes no part in any boot choice.
  wire [rmv_pkg::HOST_BIT:0] pin_low3 =
    boot_select_pins[rmv_pkg::HOST_BIT:0];
  wire is_host = pin_low3[rmv_pkg::HOST_BIT];
  wire is_byte = (pin_low3 == rmv_pkg::LOW3_BYTE);
  wire is_sci = (pin_low3 == rmv_pkg::LOW3_SCI);
  wire is_exp = (pin_low3 == rmv_pkg::LOW3_EXP);
  wire [rmv_pkg::HOST_BIT-1:0] style_nxt =
    is_host ? pin_low3[rmv_pkg::HOST_BIT-1:0] : rmv_pkg::STYLE_NONE;

  rmv_pkg::rmv_boot_t boot_nxt;

  // Low bits 011 have no boot meaning here and report no boot source.
  always_comb begin
    if (is_host) begin
      boot_nxt = rmv_pkg::RMV_BOOT_HOST;
    end else if (is_byte) begin
      boot_nxt = rmv_pkg::RMV_BOOT_BYTE;
    end else if (is_sci) begin
      boot_nxt = rmv_pkg::RMV_BOOT_SERIAL;
    end else if (is_exp) begin
      boot_nxt = rmv_pkg::RMV_BOOT_EXPANDED;
    end else begin
      boot_nxt = rmv_pkg::RMV_BOOT_NONE;
    end
  end

  // ****************************************
  // Boot registers
  // ****************************************
  rmv_pkg::rmv_boot_t boot_r;
  logic [rmv_pkg::HOST_BIT-1:0] style_r;

  // Reset values match a mode register of zero: expanded, no style.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      boot_r <= rmv_pkg::RMV_BOOT_EXPANDED;
    end else if (capture) begin
      boot_r <= boot_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      style_r <= rmv_pkg::STYLE_NONE;
    end else if (capture) begin
      style_r <= style_nxt;
    end
  end

  assign boot_kind = boot_r;
  assign host_bus_style = style_r;

  // ****************************************
  // Vector base register
  // ****************************************
  // Bits below the byte boundary are tied low at the register input, so
  // neither a write nor a reset can leave one of them set.
  logic [rmv_pkg::ADDR_W-1:0] vbase_r;
  wire [rmv_pkg::ADDR_W-1:0] vbase_nxt;

  for (genvar b = 0; b < rmv_pkg::ADDR_W; b++) begin : g_vbase
    if (b < rmv_pkg::LOW_W) begin : g_low
      assign vbase_nxt[b] = rmv_pkg::VBASE_LOW_ZERO[b];
    end else begin : g_high
      assign vbase_nxt[b] = ctl_wdata[b];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vbase_r <= rmv_pkg::VBASE_RESET;
    end else if (ctl_wr) begin
      vbase_r <= vbase_nxt;
    end
  end

  // ****************************************
  // Vector base readback
  // ****************************************
  // Reads return the register itself, so readback never lags a write.
  assign ctl_rdata = vbase_r;

  // ****************************************
  // Vector slot
  // ****************************************
  logic [rmv_pkg::LOW_W-1:0] ofs;
  logic [rmv_pkg::PRI_W-1:0] lvl;
  logic src_known;

  // Unmapped source codes come back with known low and are refused.
  rmv_vec_table u_tab (
    .src(exc_src),
    .offset(ofs),
    .level(lvl),
    .known(src_known)
  );

  // Second word sits at offset+1; offsets are even so OR never carries
  wire [rmv_pkg::LOW_W-1:0] slot_ofs =
    exc_second ? (ofs | rmv_pkg::OFS_SECOND) : ofs;
  // Fetch address: base upper bits with the slot offset below them.
  wire [rmv_pkg::ADDR_W-rmv_pkg::LOW_W-1:0] vbase_hi =
    vbase_r[rmv_pkg::ADDR_W-1:rmv_pkg::LOW_W];
  wire [rmv_pkg::ADDR_W-1:0] addr_nxt =
    {vbase_hi, slot_ofs};

  // A request taken in the same cycle as a base write still uses the old
  // base; the new one is seen from the following cycle on.
  wire take = exc_req && src_known;

  // ****************************************
  // Vector outputs
  // ****************************************
  logic [rmv_pkg::ADDR_W-1:0] vec_addr_r;
  logic [rmv_pkg::PRI_W-1:0] vec_level_r;
  logic vec_valid_r;

  // Valid is a one-cycle pulse; a held request gives one per edge.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vec_valid_r <= 1'b0;
    end else begin
      vec_valid_r <= take;
    end
  end

  // Refused sources leave address and level as they were; only the
  // pulse is withheld.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vec_addr_r <= rmv_pkg::VBASE_RESET;
    end else if (take) begin
      vec_addr_r <= addr_nxt;
    end
  end

  // Level comes from the table, so a graded source needs no change here.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vec_level_r <= rmv_pkg::PRI_NONE;
    end else if (take) begin
      vec_level_r <= lvl;
    end
  end

  assign vec_addr = vec_addr_r;
  assign vec_level = vec_level_r;
  assign vec_valid = vec_valid_r;
endmodule

/* hw/rmv_pkg.sv */
package rmv_pkg;
  localparam int ADDR_W = 24;
  localparam int MODE_W = 4;
  localparam int SRC_W = 3;
  localparam int PRI_W = 2;
  localparam int LOW_W = 8;
  localparam int NUM_SRC = 5;
  localparam logic [ADDR_W-1:0] VBASE_RESET = 24'h000000;
  localparam logic [LOW_W-1:0] VBASE_LOW_ZERO = 8'h00;
  localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
  // Source codes into the vector table
  localparam logic [SRC_W-1:0] SRC_RESET = 3'h0;
  localparam logic [SRC_W-1:0] SRC_STACK = 3'h1;
  localparam logic [SRC_W-1:0] SRC_ILLEGAL = 3'h2;
  localparam logic [SRC_W-1:0] SRC_DEBUG = 3'h3;
  localparam logic [SRC_W-1:0] SRC_TRAP = 3'h4;
  localparam logic [LOW_W-1:0] OFS_RESET = 8'h00;
  localparam logic [LOW_W-1:0] OFS_STACK = 8'h02;
  localparam logic [LOW_W-1:0] OFS_ILLEGAL = 8'h04;
  localparam logic [LOW_W-1:0] OFS_DEBUG = 8'h06;
  localparam logic [LOW_W-1:0] OFS_TRAP = 8'h08;
  localparam logic [LOW_W-1:0] OFS_SECOND = 8'h01;
  localparam logic [PRI_W-1:0] PRI_EXC = 2'h3;
  localparam logic [PRI_W-1:0] PRI_NONE = 2'h0;
  localparam logic [2:0] LOW3_BYTE = 3'h1;
  localparam logic [2:0] LOW3_SCI = 3'h2;
  localparam int HOST_BIT = 2;
  localparam logic [2:0] LOW3_EXP = 3'h0;
  localparam logic [1:0] STYLE_NONE = 2'h0;
  // Positions of the four mode bits in the mode register
  localparam int BIT_D = 3;
  localparam int BIT_C = 2;
  localparam int BIT_B = 1;
  localparam int BIT_A = 0;
  typedef enum logic [2:0] {
    RMV_BOOT_EXPANDED, RMV_BOOT_BYTE, RMV_BOOT_SERIAL, RMV_BOOT_HOST,
    RMV_BOOT_NONE
  } rmv_boot_t;
endpackage

/* hw/rmv_vec_table.sv */
module rmv_vec_table (
  input wire logic [rmv_pkg::SRC_W-1:0] src, // Exception source code
  output logic [rmv_pkg::LOW_W-1:0] offset, // Offset from vector base
  output logic [rmv_pkg::PRI_W-1:0] level, // Priority level
  output logic known // Source code is mapped
);
  always_comb begin
    offset = rmv_pkg::OFS_RESET;
    level = rmv_pkg::PRI_EXC;
    known = 1'b1;
    case (src)
      rmv_pkg::SRC_RESET: offset = rmv_pkg::OFS_RESET;
      rmv_pkg::SRC_STACK: offset = rmv_pkg::OFS_STACK;
      rmv_pkg::SRC_ILLEGAL: offset = rmv_pkg::OFS_ILLEGAL;
      rmv_pkg::SRC_DEBUG: offset = rmv_pkg::OFS_DEBUG;
      rmv_pkg::SRC_TRAP: offset = rmv_pkg::OFS_TRAP;
      default: begin
        level = rmv_pkg::PRI_NONE;
        known = 1'b0;
      end
    endcase
  end
endmodule

/* verification/rmv_sva.sv */
module rmv_sva (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic [3:0] boot_select_pins, // pins
  input wire logic ctl_wr, // write
  input wire logic [23:0] ctl_wdata, // wdata
  input wire logic [23:0] ctl_rdata, // rdata
  input wire logic exc_req, // request
  input wire logic [2:0] exc_src, // source
  input wire logic exc_second, // odd word
  input wire logic [23:0] vec_addr, // address
  input wire logic [1:0] vec_level, // level
  input wire logic vec_valid, // valid
  input wire logic [3:0] operating_mode_reg, // mode
  input wire rmv_pkg::rmv_boot_t boot_kind, // boot
  input wire logic [1:0] host_bus_style // style
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire take = exc_req && exc_src < 3'h5;
  property p_cap; $past(rst) |=> operating_mode_reg == $past(boot_select_pins);
  endproperty
  a_cap: assert property (p_cap) else $error("mode");
  property p_hold;
    !$past(rst) |=> $stable(operating_mode_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved");
  property p_byte; operating_mode_reg[2:0] == 3'h1 |->
    boot_kind == rmv_pkg::RMV_BOOT_BYTE; endproperty
  a_byte: assert property (p_byte) else $error("byte");
  property p_host; operating_mode_reg[2] |-> boot_kind ==
    rmv_pkg::RMV_BOOT_HOST && host_bus_style == operating_mode_reg[1:0];
  endproperty
  a_host: assert property (p_host) else $error("host");
  property p_low; ctl_rdata[7:0] == 8'h00; endproperty
  a_low: assert property (p_low) else $error("low");
  property p_wr; ctl_wr |=> ctl_rdata[23:8] == $past(ctl_wdata[23:8]);
  endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_go; take |=> vec_valid && vec_level == 2'h3; endproperty
  a_go: assert property (p_go) else $error("go");
  property p_no; !take |=> !vec_valid; endproperty
  a_no: assert property (p_no) else $error("refuse");
  property p_up; take |=> vec_addr[23:8] == $past(ctl_rdata[23:8]);
  endproperty
  a_up: assert property (p_up) else $error("upper");
  property p_slot; take |=> vec_addr[7:0] ==
    {4'h0, $past(exc_src), $past(exc_second)}; endproperty
  a_slot: assert property (p_slot) else $error("slot");
  c_host: cover property (boot_kind == rmv_pkg::RMV_BOOT_HOST);
  c_ref: cover property (exc_req && !take);
  c_wr: cover property (ctl_wr ##2 take);
endmodule

/* verification/rmv_seq_model.sv */
module rmv_seq_model (
  input wire logic mclk, // clock
  output logic exc_req = 0, // request
  output logic [2:0] exc_src = 3'h0, // source
  output logic exc_second = 0 // odd word
);
  timeunit 1ns;
  timeprecision 1ns;
  // Source lines are scrambled once released so stale values never match
  task req(input logic [2:0] s, input logic w);
    @(negedge mclk);
    exc_req = 1;
    exc_src = s;
    exc_second = w;
    @(negedge mclk);
    exc_req = 0;
    exc_src = ~s;
    exc_second = ~w;
  endtask
endmodule

/* verification/rmv_top_bench.sv */
module rmv_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, ctl_wr = 0, exc_req, exc_second, vv;
  logic [3:0] pins = 4'h0, om, mb;
  logic [23:0] wd = 24'h000000, rd, va;
  logic [2:0] es;
  logic [1:0] lv, hs;
  rmv_pkg::rmv_boot_t bk;
  int n_fail = 0, n_tests = 0, ea = 0, eb;
  initial forever #50 mclk = ~mclk;
  rmv_seq_model seq (.mclk, .exc_req, .exc_src(es), .exc_second);
  rmv_top dut (.mclk, .rst, .boot_select_pins(pins), .ctl_wr,
    .ctl_wdata(wd), .ctl_rdata(rd), .exc_req, .exc_src(es), .exc_second,
    .vec_addr(va), .vec_level(lv), .vec_valid(vv),
    .operating_mode_reg(om), .mode_bit_d(mb[3]), .mode_bit_c(mb[2]),
    .mode_bit_b(mb[1]), .mode_bit_a(mb[0]), .boot_kind(bk),
    .host_bus_style(hs));
  task chk(input logic [23:0] s, input logic [23:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t %h %h", $time, s, e);
    end
  endtask
  task results;
    $display("fails %0d of %0d", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    results;
  end
  initial begin
    void'($urandom(32'hf586c4e7));
    for (int m = 0; m < 16; m++) begin
      @(negedge mclk);
      rst = 1;
      pins = 4'(m);
      repeat (20) @(negedge mclk);
      chk(24'(om), 24'h000000);
      chk(va, 24'h000000);
      chk(24'(vv), 24'h000000);
      rst = 0;
      @(negedge mclk);
      pins = ~pins;
      eb = m[2] ? 3 : m[1:0] == 2'h1 ? 1 : m[1:0] == 2'h2 ? 2 : m[1] ? 4 : 0;
      chk(24'(om), 24'(m));
      chk(24'(mb), 24'(m));
      chk(24'(bk), 24'(eb));
      chk(24'(hs), 24'(m[2] ? m % 4 : 0));
      @(negedge mclk);
      chk(24'(om), 24'(m));
    end
    for (int i = 0; i < 12; i++) begin
      @(negedge mclk);
      ctl_wr = 1;
      wd = 24'($urandom);
      @(negedge mclk);
      ctl_wr = 0;
      chk(rd, wd & 24'hFFFF00);
      for (int s = 0; s < 8; s++) begin
        seq.req(3'(s), i[0]);
        if (s < 5) ea = (wd & 24'hFFFF00) | s * 2 | i % 2;
        chk(24'(vv), 24'(s < 5));
        chk(va, 24'(ea));
        chk(24'(lv), 24'h000003);
      end
    end
    // Base write and request on one edge: the request sees the old base
    ea = (wd & 24'hFFFF00) | 24'h000008;
    fork
      seq.req(3'h4, 1'b0);
      begin
        @(negedge mclk);
        ctl_wr = 1;
        wd = 24'($urandom);
        @(negedge mclk);
        ctl_wr = 0;
      end
    join
    chk(24'(vv), 24'h000001);
    chk(va, 24'(ea));
    chk(rd, wd & 24'hFFFF00);
    // Mid-run reset clears the base and the vector outputs at once
    @(negedge mclk);
    rst = 1;
    @(negedge mclk);
    chk(rd, 24'h000000);
    chk(va, 24'h000000);
    chk(24'(lv), 24'h000000);
    results;
  end
endmodule
bind rmv_top rmv_sva chk_i (.mclk, .rst, .boot_select_pins, .ctl_wr,
  .ctl_wdata, .ctl_rdata, .exc_req, .exc_src, .exc_second, .vec_addr,
  .vec_level, .vec_valid, .operating_mode_reg, .boot_kind, .host_bus_style);
